// [verilog/twp_top.sv]
// two-wire port slave: flags, clock hold, timeout, apb registers
//
// Contract
// - a plain start clears the transmit collision flag automatically
// - a repeated start leaves the collision flag unchanged on this revision
// - sw clear coinciding with address set leaves clock hold set, scl held
// - timeout in the same cycle as start drops the new transaction
// - response command 0b11 clears the data flag one cycle later
`timescale 1ns/1ns
module twp_top
  import twp_pkg::*;
#(
  parameter int TOUT = TOUT_CYC
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic irq_out
);
  twp_state_t s;
  twp_state_t n;
  logic [NSYNC-1:0] pins;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic tout_ev;
  logic wr_en;
  logic [NFLAG-1:0] sw_clr;
  logic cmd_resp;
  logic release_hold;
  logic addr_set;
  logic data_set;
  logic stop_set;
  logic coll_set;

  // mapped register check, used for the error response only
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_MASK) ||
      (a == OFS_ADDR) || (a == OFS_CMD) || (a == OFS_TXD) || (a == OFS_RXD);
  endfunction : reg_hit

  twp_sync u_sync
  (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in({sda_in, scl_in}),
    .sync_out(pins)
  );

  // bus condition decode on synchronised lines
  assign scl = pins[0];
  assign sda = pins[1];
  assign scl_rise = scl & ~s.scl_d;
  assign scl_fall = ~scl & s.scl_d;
  assign start_ev = s.ctrl[CTRL_EN_BIT] & s.scl_d & scl & s.sda_d & ~sda;
  assign stop_ev = s.ctrl[CTRL_EN_BIT] & s.scl_d & scl & ~s.sda_d & sda;
  assign tout_ev = s.ctrl[CTRL_TOUT_BIT] & s.busy &
    (s.tcnt == TCNT_W'(TOUT - 1));

  // apb write strobes, taken at the completing edge
  assign wr_en = psel_in & penable_in & s.pready & pwrite_in;
  assign sw_clr = (wr_en && paddr_in == OFS_STAT) ? pwdata_in[NFLAG-1:0] : 4'h0;
  assign cmd_resp = wr_en && paddr_in == OFS_CMD && pwdata_in[1:0] == CMD_RESP;
  assign release_hold = sw_clr[SB_ASF] | sw_clr[SB_DF] | cmd_resp;

  // next-state logic
  always_comb
  begin
    n = s;
    addr_set = 1'b0;
    data_set = 1'b0;
    stop_set = 1'b0;
    coll_set = 1'b0;
    n.scl_d = scl;
    n.sda_d = sda;
    // apb slave: one wait state, data and error registered
    n.pready = psel_in & penable_in & ~s.pready;
    n.pslverr = psel_in & penable_in & ~s.pready & ~reg_hit(paddr_in);
    if (psel_in && penable_in && !s.pready && !pwrite_in)
    begin
      case (paddr_in)
        OFS_CTRL: n.prdata = {30'h0000_0000, s.ctrl};
        OFS_STAT: n.prdata = {26'h000_0000, s.hold, s.busy, s.tof, s.coll, s.asf, s.df};
        OFS_MASK: n.prdata = {28'h000_0000, s.mask};
        OFS_ADDR: n.prdata = {25'h000_0000, s.addr};
        OFS_TXD: n.prdata = {24'h00_0000, s.txd};
        OFS_RXD: n.prdata = {24'h00_0000, s.rxd};
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_en && paddr_in == OFS_CTRL)
    begin
      n.ctrl = pwdata_in[1:0];
    end
    if (wr_en && paddr_in == OFS_MASK)
    begin
      n.mask = pwdata_in[NFLAG-1:0];
    end
    if (wr_en && paddr_in == OFS_ADDR)
    begin
      n.addr = pwdata_in[6:0];
    end
    if (wr_en && paddr_in == OFS_TXD)
    begin
      n.txd = pwdata_in[7:0];
    end
    // timeout counter runs while busy and scl stands still, so a start can meet it
    if (s.busy && !scl_rise && !scl_fall && s.ctrl[CTRL_TOUT_BIT] && !tout_ev)
    begin
      n.tcnt = s.tcnt + 1'b1;
    end
    else
    begin
      n.tcnt = '0;
    end
    // protocol engine
    if (tout_ev)
    begin
      // a start in this same cycle is lost with the old transfer
      n.st = ST_IDLE;
      n.busy = 1'b0;
      n.sda_oe = 1'b0;
    end
    else if (start_ev)
    begin
      n.st = ST_ADDR;
      n.busy = 1'b1;
      n.bitcnt = 3'h0;
      n.bdone = 1'b0;
      n.sda_oe = 1'b0;
    end
    else if (stop_ev)
    begin
      stop_set = (s.st != ST_IDLE);
      n.st = ST_IDLE;
      n.busy = 1'b0;
      n.sda_oe = 1'b0;
    end
    else
    begin
      case (s.st)
        ST_IDLE:
        begin
          n.st = ST_IDLE;
        end
        ST_ADDR, ST_DATA:
        begin
          if (scl_rise && s.st == ST_DATA && s.rw && !s.sda_oe && !sda)
          begin
            // released a one but saw a zero: lost the bus
            coll_set = 1'b1;
            n.st = ST_IDLE;
          end
          else if (scl_rise)
          begin
            n.shreg = s.rw && s.st == ST_DATA ? s.shreg : {s.shreg[6:0], sda};
            n.bitcnt = s.bitcnt + 1'b1;
            n.bdone = (s.bitcnt == 3'h7);
          end
          else if (scl_fall && s.bdone)
          begin
            n.bdone = 1'b0;
            if (s.st == ST_ADDR)
            begin
              n.st = (s.shreg[7:1] == s.addr) ? ST_AACK : ST_IDLE;
              n.sda_oe = (s.shreg[7:1] == s.addr);
              n.rw = s.shreg[0];
            end
            else
            begin
              n.st = ST_DACK;
              n.sda_oe = ~s.rw;
              n.rxd = s.rw ? s.rxd : s.shreg;
            end
          end
          else if (scl_fall && s.st == ST_DATA && s.rw)
          begin
            n.shreg = {s.shreg[6:0], 1'b0};
            n.sda_oe = ~s.shreg[6];
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            n.sda_oe = 1'b0;
            n.st = ST_DATA;
            n.bitcnt = 3'h0;
            addr_set = 1'b1;
          end
        end
        ST_DACK:
        begin
          if (scl_rise)
          begin
            n.nack = sda;
          end
          if (scl_fall)
          begin
            n.sda_oe = 1'b0;
            n.bitcnt = 3'h0;
            n.st = (s.rw && s.nack) ? ST_IDLE : ST_DATA;
            data_set = ~(s.rw && s.nack);
          end
        end
        default:
        begin
          n.st = ST_IDLE;
        end
      endcase
    end
    // hold: a set in the same cycle as a clear wins, so scl stays low
    n.hold = (s.hold & ~release_hold & ~tout_ev) | addr_set | data_set;
    // transmit byte loaded when software lets scl go
    if (s.hold && !n.hold && s.rw && s.st == ST_DATA)
    begin
      n.shreg = s.txd;
      n.sda_oe = ~s.txd[7];
    end
    // sticky flags, set wins over clear
    n.asf = (s.asf & ~sw_clr[SB_ASF]) | addr_set | stop_set;
    n.df = (s.df & ~sw_clr[SB_DF] & ~s.df_pend) | data_set;
    n.df_pend = cmd_resp;
    n.coll = (s.coll & ~sw_clr[SB_COLL] & ~(start_ev & ~s.busy & ~tout_ev)) | coll_set;
    n.tof = (s.tof & ~sw_clr[SB_TOUT]) | tout_ev;
    n.irq = |({n.tof, n.coll, n.asf, n.df} & s.mask);
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ctrl <= CTRL_RST;
      s.mask <= MASK_RST;
      s.addr <= ADDR_RST;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  // outputs straight from flops; open-drain pins drive only low
  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = s.hold;
  assign sda_oe_out = s.sda_oe;
  assign irq_out = s.irq;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_start_clr;
    start_ev && !s.busy && !tout_ev && !coll_set |=> !s.coll;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start left collision set");

  property p_rstart_keep;
    start_ev && s.busy && !tout_ev && sw_clr == 4'h0 |=> s.coll == $past(s.coll);
  endproperty
  a_rstart_keep: assert property (p_rstart_keep) else $error("repeated start changed flag");

  property p_race_hold;
    addr_set && sw_clr[SB_ASF] |=> s.asf && s.hold ##1 scl_oe_out;
  endproperty
  a_race_hold: assert property (p_race_hold) else $error("race did not keep hold");

  property p_clr_release;
    s.hold && sw_clr[SB_ASF] && !addr_set && !data_set |=> !scl_oe_out;
  endproperty
  a_clr_release: assert property (p_clr_release) else $error("clear did not release scl");

  property p_drop;
    start_ev && tout_ev |=> s.st == ST_IDLE && !s.busy;
  endproperty
  a_drop: assert property (p_drop) else $error("start at timeout not dropped");

  sequence s_df_late;
    s.df ##1 !s.df;
  endsequence

  property p_df_delay;
    cmd_resp && s.df && !data_set |=> s_df_late;
  endproperty
  a_df_delay: assert property (p_df_delay) else $error("data flag clear timing wrong");
endmodule : twp_top

// [verilog/twp_pkg.sv]
// package for the two-wire port: register map, fields, states, carriers
package twp_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_TXD = 8'h14;
  localparam logic [7:0] OFS_RXD = 8'h18;
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TOUT_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // status fields: four sticky flags, then read-only state
  localparam int SB_DF = 0;
  localparam int SB_ASF = 1;
  localparam int SB_COLL = 2;
  localparam int SB_TOUT = 3;
  localparam int SB_BUSY = 4;
  localparam int SB_HOLD = 5;
  localparam int NFLAG = 4;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [6:0] ADDR_RST = 7'h00;
  // slave response command code
  localparam logic [1:0] CMD_RESP = 2'h3;
  // bus timeout: cycles without an scl edge while busy
  localparam int TCNT_W = 16;
  localparam int TOUT_CYC = 1000;
  // input synchroniser width: scl and sda
  localparam int NSYNC = 2;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_AACK = 5'h04,
    ST_DATA = 5'h08,
    ST_DACK = 5'h10
  } twp_st_t;

  typedef struct packed
  {
    logic [NSYNC-1:0] meta;
    logic [NSYNC-1:0] sync;
  } twp_sync_t;

  typedef struct packed
  {
    twp_st_t st;
    logic busy;
    logic [2:0] bitcnt;
    logic bdone;
    logic nack;
    logic [7:0] shreg;
    logic rw;
    logic sda_oe;
    logic hold;
    logic df;
    logic asf;
    logic coll;
    logic tof;
    logic df_pend;
    logic [1:0] ctrl;
    logic [3:0] mask;
    logic [6:0] addr;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [TCNT_W-1:0] tcnt;
    logic scl_d;
    logic sda_d;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } twp_state_t;
endpackage : twp_pkg

// [verilog/twp_sync.sv]
// two-flop synchroniser for the scl and sda pins
`timescale 1ns/1ns
module twp_sync
  import twp_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [NSYNC-1:0] async_in,
  output logic [NSYNC-1:0] sync_out
);
  twp_sync_t s;
  twp_sync_t n;

  // first stage feeds only the second
  always_comb
  begin
    n.meta = async_in;
    n.sync = s.meta;
  end

  // register, lines idle high after reset
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s.meta <= {NSYNC{1'b1}};
      s.sync <= {NSYNC{1'b1}};
    end
    else
    begin
      s <= n;
    end
  end

  assign sync_out = s.sync;
endmodule : twp_sync

// [tb/twp_mst.sv]
// open-drain bus master model on the two-wire port pins
`timescale 1ns/1ns
module twp_mst
(
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_out,
  output logic sda_oe_out
);
  // both lines released, clock stands still
  initial
  begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  // step off the sampling edge of the 100 mhz bench clock
  task automatic align();
    while ($time % 10 != 7)
      #1;
  endtask : align
  // release scl, let the wire settle, wait out a slave holding it low
  task automatic rel_scl();
    int n;
    scl_oe_out = 1'b0;
    #10;
    for (n = 0; n < 3000 && scl_in !== 1'b1; n++)
      #10;
  endtask : rel_scl
  // start or repeated start; gap is how long scl stands high before sda falls
  task automatic start(input int gap = 20);
    align();
    sda_oe_out = 1'b0;
    #20;
    rel_scl();
    #(gap - 10);
    sda_oe_out = 1'b1;
    #20;
    scl_oe_out = 1'b1;
    #20;
  endtask : start
  // stop, then the clock stands still
  task automatic stop();
    align();
    sda_oe_out = 1'b1;
    #20;
    rel_scl();
    #10;
    sda_oe_out = 1'b0;
    #40;
  endtask : stop
  // one 80 ns bit, sda sampled mid high
  task automatic bit_x(input logic b, output logic r);
    align();
    sda_oe_out = !b;
    #20;
    rel_scl();
    #10;
    r = sda_in;
    #20;
    scl_oe_out = 1'b1;
    #20;
  endtask : bit_x
  // msb first byte, then the acknowledge slot
  task automatic byte_x(input logic [7:0] b, output logic ack);
    int i;
    logic r;
    for (i = 7; i >= 0; i--)
      bit_x(b[i], r);
    bit_x(1'b1, ack);
  endtask : byte_x
endmodule : twp_mst

// [tb/twp_top_tb.sv]
// self-checking bench for the two-wire port flags and clock hold
`timescale 1ns/1ns
module twp_top_tb
  import twp_pkg::*;
;
  typedef struct packed {logic [31:0] m; logic [31:0] d; logic e;} twp_exp_t;
  logic clk_in, resetn_in, psel, penable, pwrite, m_scl_oe, m_sda_oe, ack;
  logic pready_out, pslverr_out, scl_oe_out, sda_oe_out, irq_out;
  logic [7:0] paddr, d_r;
  logic [6:0] a_r;
  logic [31:0] pwdata, prdata_out;
  int seed, err_total, num_checks;
  twp_exp_t q[$];
  twp_exp_t ex;
  // open-drain wires with pull-ups
  wire scl_w = !(scl_oe_out | m_scl_oe);
  wire sda_w = !(sda_oe_out | m_sda_oe);

  twp_top #(.TOUT(200)) i_twp_top (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(),
    .sda_oe_out(sda_oe_out), .irq_out(irq_out));
  twp_mst i_twp_mst (.scl_in(scl_w), .sda_in(sda_w), .scl_oe_out(m_scl_oe),
    .sda_oe_out(m_sda_oe));

  // 100 mhz clock
  initial
  begin
    clk_in = 1'b0;
    forever
      #5 clk_in = !clk_in;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic complete_run();
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // one apb transfer; m picks the read bits compared
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, m,
    input logic e);
    int n;
    @(posedge clk_in);
    q.push_back('{m, v & m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    for (n = 0; n < 20 && pready_out !== 1'b1; n++)
      @(posedge clk_in);
    if (n == 20)
      chk({31'h0, pready_out}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic hold_wt();
    int n;
    for (n = 0; n < 60 && scl_oe_out !== 1'b1; n++)
      @(posedge clk_in);
    chk({31'h0, scl_oe_out}, 32'h1);
  endtask : hold_wt

  // oldest note against each finished transfer
  always @(posedge clk_in)
    if (pready_out === 1'b1 && q.size() > 0)
    begin
      ex = q.pop_front();
      chk({31'h0, pslverr_out}, {31'h0, ex.e});
      chk(prdata_out & ex.m, ex.d);
    end

  initial
  begin
    #300000;
    err_total++;
    complete_run();
  end

  initial
  begin
    seed = 32'h8195_2a83;
    {resetn_in, psel, penable, pwrite, paddr, pwdata} = '0;
    a_r = 7'($random(seed));
    d_r = 8'($random(seed));
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    // reset values, an unmapped place
    apb(1'b0, OFS_CTRL, 32'h0, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, OFS_MASK, 32'h0, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, 8'h1C, 32'h0, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, OFS_ADDR, {25'h0, a_r}, 32'h0, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h1, 32'h0, 1'b0);
    // addressed write, masked then unmasked flag
    // the flag clear completes on the very edge that sets the flag
    i_twp_mst.start();
    fork
      i_twp_mst.byte_x({a_r, 1'b0}, ack);
      begin
        #690;
        apb(1'b1, OFS_STAT, 32'h2, 32'h0, 1'b0);
      end
    join
    chk({31'h0, ack}, 32'h0);
    hold_wt();
    apb(1'b0, OFS_STAT, 32'h22, 32'h22, 1'b0);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, OFS_MASK, 32'hF, 32'h0, 1'b0);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    apb(1'b1, OFS_STAT, 32'h2, 32'h0, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0, 32'h22, 1'b0);
    chk({31'h0, scl_oe_out}, 32'h0);
    // data byte, response command
    i_twp_mst.byte_x(d_r, ack);
    chk({31'h0, ack}, 32'h0);
    hold_wt();
    apb(1'b0, OFS_RXD, {24'h0, d_r}, 32'hFF, 1'b0);
    apb(1'b1, OFS_CMD, 32'h3, 32'h0, 1'b0);
    @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0, 32'h21, 1'b0);
    i_twp_mst.stop();
    apb(1'b1, OFS_STAT, 32'hF, 32'h0, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0, 32'h1F, 1'b0);
    // read transfer broken by a collision
    i_twp_mst.start();
    i_twp_mst.byte_x({a_r, 1'b1}, ack);
    hold_wt();
    apb(1'b1, OFS_TXD, {24'h0, 1'b1, d_r[6:0]}, 32'h0, 1'b0);
    apb(1'b1, OFS_STAT, 32'h2, 32'h0, 1'b0);
    i_twp_mst.bit_x(1'b0, ack);
    i_twp_mst.start();
    apb(1'b0, OFS_STAT, 32'h4, 32'h4, 1'b0);
    i_twp_mst.stop();
    i_twp_mst.start();
    apb(1'b0, OFS_STAT, 32'h0, 32'h4, 1'b0);
    i_twp_mst.stop();
    apb(1'b1, OFS_STAT, 32'hF, 32'h0, 1'b0);
    // timeout on the cycle of a repeated start: scl high for 200 cycles
    apb(1'b1, OFS_CTRL, 32'h3, 32'h0, 1'b0);
    i_twp_mst.start();
    i_twp_mst.byte_x({a_r ^ 7'h01, 1'b0}, ack);
    chk({31'h0, ack}, 32'h1);
    i_twp_mst.start(2000);
    i_twp_mst.byte_x({a_r, 1'b0}, ack);
    chk({31'h0, ack}, 32'h1);
    apb(1'b0, OFS_STAT, 32'h8, 32'h18, 1'b0);
    i_twp_mst.stop();
    apb(1'b1, OFS_STAT, 32'hF, 32'h0, 1'b0);
    repeat (4) @(posedge clk_in);
    complete_run();
  end
endmodule : twp_top_tb
